/* File: inc/psr_pkg.sv */
// Constants, action codes and byte helpers for the stamp rewriter.
// Assumes untagged Ethernet with PTP over L2, IPv4/UDP or IPv6/UDP.
// What this block does
// [R1] Frame start pulses stamp unit, time captured
// [R2] Subtract fixed latency from captured time
// [R3] Asymmetry adjusts correction; added on ingress Sync
// [R4] Ingress frames delayed while analyzer classifies copy
// [R5] Ingress match: write reserved field, 4 bytes
// [R6] No match: pass unmodified, drop capture
// [R7] Ingress write nanoseconds minus latency, new FCS
// [R8] Rewriter drains continuously, byte counter locates fields
// [R9] Bad original FCS gives inverted new FCS
// [R10] IPv4 rewrite forces transport checksum to zero
// [R11] IPv6 rewrite fixes spare bytes for checksum
// [R12] Egress frames delayed while analyzer classifies copy
// [R13] Egress Sync: write 10-byte origin stamp
// [R14] Egress Delay_req: write, save, send identifier
// [R15] Write-and-save stores stamp with identifier
// [R16] Stamp FIFO buffers sets, processor reads them
// [R17] Egress origin equals raw time plus latency
// [R18] Egress Delay_req correction gets asymmetry added
// [R19] Engine may preload send time, correction zero
// [R20] Transit mode writes residence into correction
// [R21] Delay_resp and others pass unmodified
// [R22] System supplies reference clock and load pulse
// [R23] Decryption sits before classification on ingress
// [R24] Local time is nanoseconds plus seconds
// [R25] Each capture stays paired with its frame
package psr_pkg;
  localparam int DELAY_DEPTH = 16; // Frame delay in bytes
  localparam logic [10:0] POS_ETYPE = 11'h00C; // Ethertype
  localparam logic [10:0] BASE_L2 = 11'h00E; // Header on L2
  localparam logic [10:0] BASE_IP4 = 11'h02A; // Header on IPv4
  localparam logic [10:0] BASE_IP6 = 11'h03E; // Header on IPv6
  localparam logic [10:0] POS_UDP_CSUM = 11'h028; // IPv4 UDP sum
  localparam logic [10:0] OFF_MSGLEN = 11'h002; // Message length
  localparam logic [10:0] OFF_DOMAIN = 11'h004; // Domain number
  localparam logic [10:0] OFF_CORR = 11'h008; // Correction field
  localparam logic [10:0] OFF_RSVD = 11'h010; // Reserved bytes
  localparam logic [10:0] OFF_ORIGIN = 11'h022; // Origin stamp
  localparam logic [10:0] LEN_CORR = 11'h008; // Correction size
  localparam logic [10:0] LEN_RSVD = 11'h004; // Reserved size
  localparam logic [10:0] LEN_ORIGIN = 11'h00A; // Origin size
  localparam logic [10:0] ID_BYTES = 11'h010; // Identifier size
  localparam logic [15:0] ETYPE_PTP = 16'h88F7; // PTP on L2
  localparam logic [15:0] ETYPE_IP4 = 16'h0800; // IPv4
  localparam logic [15:0] ETYPE_IP6 = 16'h86DD; // IPv6
  localparam logic [3:0] MT_SYNC = 4'h0; // Sync message
  localparam logic [3:0] MT_DREQ = 4'h1; // Delay_req message
  localparam logic [31:0] NS_PER_SEC = 32'h3B9ACA00; // 1e9
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF; // CRC seed
  localparam logic [31:0] CRC_GOOD = 32'hDEBB20E3; // Residue
  localparam logic [31:0] CRC_POLY = 32'hEDB88320; // Reflected

  // Action the analyzer hands the stamp unit and rewriter
  typedef enum logic [1:0] {
    PSR_PASS_UNMODIFIED_ACTION = 2'b00,
    PSR_WRITE = 2'b01,
    PSR_WRITE_SAVE = 2'b10
  } psr_action_e;

  // One byte of the Ethernet CRC, LSB first
  function automatic logic [31:0] crc_byte(
    input logic [31:0] c,
    input logic [7:0] b
  );
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction : crc_byte

  // Ones-complement 16-bit add with end-around carry
  function automatic logic [15:0] ones_add(
    input logic [15:0] a,
    input logic [15:0] b
  );
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction : ones_add
endpackage : psr_pkg

/* File: logic/psr_delay_line.sv */
// Fixed-length byte delay with a tail mark on the last TAIL entries.
// Assumes the source keeps valid high through each whole frame.
`timescale 1ns/1ps
`default_nettype none
module psr_delay_line
#(
  parameter int W = 11, // Entry width
  parameter int D = 16, // Stages
  parameter int TAIL = 4 // Entries marked before frame end
)
(
  input wire logic clk, // Clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic [W-1:0] din, // Entry in
  input wire logic last_in, // Entry in ends a frame
  output logic [W-1:0] dout, // Entry out
  output logic tail_out // Entry out is in the tail
);
  logic [W-1:0] data_reg [D]; // Stage contents
  logic [D-1:0] tail_reg; // Tail marks

  // Shift every cycle; a frame end marks itself and the TAIL-1 entries ahead of it
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      for (int k = 0; k < D; k++)
        data_reg[k] <= '0;
      tail_reg <= '0;
    end
    else
    begin
      data_reg[0] <= din;
      tail_reg[0] <= last_in;
      for (int k = 1; k < D; k++)
      begin
        data_reg[k] <= data_reg[k-1];
        tail_reg[k] <= tail_reg[k-1] | (last_in && (k < TAIL));
      end
    end
  end

  assign dout = data_reg[D-1];
  assign tail_out = tail_reg[D-1];
endmodule : psr_delay_line
`default_nettype wire

/* File: logic/psr_stamp_fifo.sv */
// Buffer of identifier plus stamp sets with a read port.
// Assumes at most one push and one pop a cycle.
`timescale 1ns/1ps
`default_nettype none
module psr_stamp_fifo
#(
  parameter int W = 208, // Set width
  parameter int DEPTH = 16, // Sets held
  parameter int AW = $clog2(DEPTH) // Pointer width
)
(
  input wire logic clk, // Clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic wr_valid, // Push a set
  input wire logic [W-1:0] wr_data, // Set pushed
  input wire logic rd_req, // Pop one set
  output logic rd_valid, // Popped set on rd_data
  output logic [W-1:0] rd_data, // Popped set
  output logic empty, // Nothing held
  output logic full // No room, pushes are dropped
);
  logic [W-1:0] mem [DEPTH]; // Storage
  logic [AW:0] wp_reg; // Write pointer with wrap bit
  logic [AW:0] rp_reg; // Read pointer with wrap bit
  logic do_wr; // Push accepted
  logic do_rd; // Pop accepted

  assign empty = (wp_reg == rp_reg);
  assign full = (wp_reg[AW] != rp_reg[AW]) &&
                (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
  assign do_wr = wr_valid && !full;
  assign do_rd = rd_req && !empty;

  // Storage writes; a push into a full buffer is lost
  always_ff @(posedge clk)
  begin
    if (do_wr)
      mem[wp_reg[AW-1:0]] <= wr_data; // [R16]
  end

  // Pointers and read answer
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
      rd_valid <= 1'b0;
      rd_data <= '0;
    end
    else
    begin
      wp_reg <= wp_reg + (AW+1)'(do_wr);
      rp_reg <= rp_reg + (AW+1)'(do_rd);
      rd_valid <= do_rd;
      if (do_rd)
        rd_data <= mem[rp_reg[AW-1:0]]; // [R16]
    end
  end
endmodule : psr_stamp_fifo
`default_nettype wire

/* File: logic/psr_stamp_rewriter.sv */
// One-step stamp rewriter: ingress and egress paths of one port.
// Assumes byte streams, valid high for a whole frame, FCS last.
`timescale 1ns/1ps
`default_nettype none
module psr_stamp_rewriter
#(
  parameter int DELAY = psr_pkg::DELAY_DEPTH, // 13 to 18 only
  parameter int TS_DEPTH = 16 // Saved stamp sets
)
(
  input wire logic clk, // Datapath clock
  input wire logic resetn, // Synchronous reset, active low
  input wire logic [47:0] time_sec, // Local seconds count
  input wire logic [31:0] time_ns, // Local nanosecond count
  input wire logic boundary_clock_mode, // Stamping enabled
  input wire logic end_to_end_transit_clock, // Egress TC mode
  input wire logic [7:0] domain_num, // Domain served
  input wire logic [31:0] fixed_latency_ns, // Detect latency
  input wire logic [63:0] link_asym, // Asymmetry, ns x 2^16
  input wire logic [6:0] id_offset, // Identifier start
  input wire logic ing_in_valid, // Line byte valid
  input wire logic ing_in_sof, // Line frame start
  input wire logic ing_in_last, // Line frame end
  input wire logic [7:0] ing_in_data, // Line byte
  output logic ing_out_valid, // System byte valid
  output logic ing_out_sof, // System frame start
  output logic ing_out_last, // System frame end
  output logic [7:0] ing_out_data, // System byte
  input wire logic egr_in_valid, // System byte valid
  input wire logic egr_in_sof, // System frame start
  input wire logic egr_in_last, // System frame end
  input wire logic [7:0] egr_in_data, // System byte
  output logic egr_out_valid, // Line byte valid
  output logic egr_out_sof, // Line frame start
  output logic egr_out_last, // Line frame end
  output logic [7:0] egr_out_data, // Line byte
  input wire logic ts_rd_req, // Pop one saved set
  output logic ts_rd_valid, // Set on read outputs
  output logic [127:0] ts_rd_id, // Frame identifier
  output logic [79:0] ts_rd_stamp, // Seconds and ns
  output logic ts_empty, // No set saved
  output logic ts_full // Buffer full
);
  logic [1:0] iv; // Input valid per direction
  logic [1:0] isof; // Input frame start
  logic [1:0] ilast; // Input frame end
  logic [7:0] idat [2]; // Input byte

  // Ingress sees frames after any decryption stage upstream
  assign iv = {egr_in_valid, ing_in_valid}; // [R23]
  assign isof = {egr_in_sof, ing_in_sof};
  assign ilast = {egr_in_last, ing_in_last};
  assign idat[0] = ing_in_data;
  assign idat[1] = egr_in_data;

  for (genvar g = 0; g < 2; g++)
  begin : dir
    localparam bit EGR = (g == 1); // Egress path
    localparam logic [10:0] WOFF =
      EGR ? psr_pkg::OFF_ORIGIN : psr_pkg::OFF_RSVD;
    logic v;
    logic [7:0] d;
    logic [10:0] ipos; // Input byte position
    logic [10:0] ipos_reg;
    logic [79:0] cap_reg; // Time at frame start
    logic [7:0] etype_reg; // Ethertype high byte, then message length high byte
    logic [10:0] base_reg; // Header start, zero if none
    logic [3:0] mt_reg; // Message type
    logic [10:0] mlen_reg; // Message length
    logic [63:0] corr_reg; // Original correction
    logic [31:0] rsvd_reg; // Original reserved bytes
    logic [127:0] id_reg; // Identifier bytes
    logic [31:0] crci_reg; // Input CRC
    logic bad_reg; // Original FCS bad
    psr_pkg::psr_action_e act_reg; // Action for the frame
    logic [79:0] stamp_reg; // Stamp paired with the frame
    logic [10:0] wbase_reg; // Header start, latched
    logic [10:0] wsize_reg; // Bytes of stamp written
    logic [1:0] ipk_reg; // {IPv6, IPv4}
    logic corr_en_reg; // Correction is rewritten
    logic tcd_reg; // Residence added to correction
    logic save_reg; // Set saved at frame end
    logic [63:0] cnew_reg; // New correction
    logic [15:0] spare_reg; // Original spare word
    logic [32:0] esum; // Nanoseconds plus latency
    logic [31:0] isub; // Nanoseconds minus latency
    logic [79:0] egr_st;
    logic [31:0] res; // Residence in ns
    logic [10:0] dent; // Delay line output fields
    logic dv;
    logic ds;
    logic dlast;
    logic [7:0] dd;
    logic dtail; // Output byte is FCS
    logic [10:0] opos; // Output byte position
    logic [10:0] opos_reg;
    logic [10:0] k_w; // Index into stamp field
    logic [10:0] k_c;
    logic [10:0] sp;
    logic [79:0] wsh;
    logic [63:0] csh;
    logic [31:0] fcs;
    logic [31:0] fsh;
    logic [15:0] spn;
    logic [7:0] ob;
    logic mod; // Byte is a payload change
    logic [15:0] acc_reg; // Sum of old minus new words
    logic [31:0] crco_reg; // Output CRC
    logic [1:0] tcnt_reg; // FCS byte index
    logic ov_reg; // Registered outputs
    logic osof_reg;
    logic olast_reg;
    logic [7:0] odat_reg;

    assign v = iv[g];
    assign d = idat[g];
    assign ipos = isof[g] ? 11'h000 : ipos_reg;
    assign sp = base_reg + mlen_reg;

    // Input byte counter and frame-start capture
    always_ff @(posedge clk)
    begin
      if (!resetn)
      begin
        ipos_reg <= 11'h000;
        cap_reg <= 80'h0;
      end
      else if (v)
      begin
        ipos_reg <= ipos + 11'h001;
        if (isof[g])
          cap_reg <= {time_sec, time_ns}; // [R1] [R24]
      end
    end

    // Analyzer: header fields taken from the copy of the stream
    always_ff @(posedge clk)
    begin
      if (!resetn)
      begin
        etype_reg <= 8'h00;
        base_reg <= 11'h000;
        mt_reg <= 4'h0;
        mlen_reg <= 11'h000;
        corr_reg <= 64'h0;
        rsvd_reg <= 32'h0;
        id_reg <= 128'h0;
        spare_reg <= 16'h0000;
      end
      else if (v)
      begin
        if (ipos == psr_pkg::POS_ETYPE)
          etype_reg <= d;
        if (ipos == psr_pkg::POS_ETYPE + 11'h001)
        begin
          case ({etype_reg, d}) // [R4] [R12]
            psr_pkg::ETYPE_PTP: base_reg <= psr_pkg::BASE_L2;
            psr_pkg::ETYPE_IP4: base_reg <= psr_pkg::BASE_IP4;
            psr_pkg::ETYPE_IP6: base_reg <= psr_pkg::BASE_IP6;
            default: base_reg <= 11'h000;
          endcase
        end
        if (base_reg != 11'h000)
        begin
          if (ipos == base_reg)
            mt_reg <= d[3:0];
          if (ipos == base_reg + psr_pkg::OFF_MSGLEN + 11'h001)
            mlen_reg <= {etype_reg[2:0], d};
          if (ipos == base_reg + psr_pkg::OFF_MSGLEN)
            etype_reg <= d;
          if (ipos - (base_reg + psr_pkg::OFF_CORR) <
              psr_pkg::LEN_CORR)
            corr_reg <= {corr_reg[55:0], d};
          if (ipos - (base_reg + psr_pkg::OFF_RSVD) <
              psr_pkg::LEN_RSVD)
            rsvd_reg <= {rsvd_reg[23:0], d}; // [R19]
          if (ipos - (base_reg + {4'h0, id_offset}) <
              psr_pkg::ID_BYTES)
            id_reg <= {id_reg[119:0], d}; // [R14]
          if (ipos == sp)
            spare_reg[15:8] <= d; // [R11]
          if (ipos == sp + 11'h001)
            spare_reg[7:0] <= d; // [R11]
        end
      end
    end

    // Stamp arithmetic with wrap at one second
    always_comb
    begin
      esum = {1'b0, cap_reg[31:0]} + {1'b0, fixed_latency_ns};
      isub = cap_reg[31:0] - fixed_latency_ns; // [R2]
      if (cap_reg[31:0] < fixed_latency_ns)
        isub = isub + psr_pkg::NS_PER_SEC;
      egr_st = {cap_reg[79:32], esum[31:0]}; // [R17]
      if (esum >= {1'b0, psr_pkg::NS_PER_SEC})
        egr_st = {cap_reg[79:32] + 48'h1,
                  esum[31:0] - psr_pkg::NS_PER_SEC};
      res = stamp_reg[31:0] - rsvd_reg; // [R20]
      if (stamp_reg[31:0] < rsvd_reg)
        res = res + psr_pkg::NS_PER_SEC;
    end

    // Decision per frame; the capture is copied only on a match,
    // so it rides with its own frame through the delay line
    always_ff @(posedge clk)
    begin
      if (!resetn)
      begin
        act_reg <= psr_pkg::PSR_PASS_UNMODIFIED_ACTION;
        stamp_reg <= 80'h0;
        wbase_reg <= 11'h000;
        wsize_reg <= 11'h000;
        ipk_reg <= 2'b00;
        corr_en_reg <= 1'b0;
        tcd_reg <= 1'b0;
        save_reg <= 1'b0;
        cnew_reg <= 64'h0;
      end
      else
      begin
        if (dv && ds) // Previous frame has fully left
        begin
          act_reg <= psr_pkg::PSR_PASS_UNMODIFIED_ACTION; // [R6]
          corr_en_reg <= 1'b0;
        end
        if (v && isof[g])
          save_reg <= 1'b0;
        if (v && base_reg != 11'h000 &&
            ipos == base_reg + psr_pkg::OFF_DOMAIN)
        begin
          if (boundary_clock_mode && d == domain_num &&
              (mt_reg == psr_pkg::MT_SYNC ||
               mt_reg == psr_pkg::MT_DREQ)) // [R21]
          begin
            wbase_reg <= base_reg; // [R25]
            ipk_reg <= {base_reg == psr_pkg::BASE_IP6,
                        base_reg == psr_pkg::BASE_IP4};
            if (!EGR)
            begin
              act_reg <= psr_pkg::PSR_WRITE; // [R5]
              stamp_reg <= {48'h0, isub}; // [R7]
              wsize_reg <= psr_pkg::LEN_RSVD; // [R5]
              corr_en_reg <= (mt_reg == psr_pkg::MT_SYNC); // [R3]
              tcd_reg <= 1'b0;
            end
            else if (mt_reg == psr_pkg::MT_SYNC)
            begin
              act_reg <= psr_pkg::PSR_WRITE; // [R13]
              stamp_reg <= egr_st; // [R17]
              wsize_reg <= psr_pkg::LEN_ORIGIN; // [R13]
              tcd_reg <= 1'b0;
            end
            else if (end_to_end_transit_clock)
            begin
              act_reg <= psr_pkg::PSR_WRITE; // [R20]
              stamp_reg <= egr_st;
              wsize_reg <= 11'h000; // Origin keeps software time
              corr_en_reg <= 1'b1;
              tcd_reg <= 1'b1;
            end
            else
            begin
              act_reg <= psr_pkg::PSR_WRITE_SAVE; // [R14]
              stamp_reg <= egr_st; // [R17]
              wsize_reg <= psr_pkg::LEN_ORIGIN; // [R14]
              corr_en_reg <= 1'b1; // [R18]
              tcd_reg <= 1'b0;
              save_reg <= 1'b1; // [R15]
            end
          end
        end
        // New correction once original and reserved are in
        if (v && base_reg != 11'h000 && ipos == base_reg +
            psr_pkg::OFF_RSVD + psr_pkg::LEN_RSVD)
          cnew_reg <= corr_reg + link_asym +
                      (tcd_reg ? {16'h0000, res, 16'h0000}
                               : 64'h0); // [R3] [R18] [R20]
        if (v && ilast[g])
          save_reg <= 1'b0;
      end
    end

    // Original FCS check over the input stream
    always_ff @(posedge clk)
    begin
      if (!resetn)
      begin
        crci_reg <= psr_pkg::CRC_INIT;
        bad_reg <= 1'b0;
      end
      else if (v)
      begin
        crci_reg <= psr_pkg::crc_byte(
          isof[g] ? psr_pkg::CRC_INIT : crci_reg, d);
        if (ilast[g])
          bad_reg <= (psr_pkg::crc_byte(crci_reg, d) !=
                      psr_pkg::CRC_GOOD); // [R9]
      end
    end

    // Frame delay; the analyzer runs ahead of the output
    psr_delay_line #(
      .W(11),
      .D(DELAY),
      .TAIL(4)
    ) u_delay (
      .clk(clk),
      .resetn(resetn),
      .din({v, v && isof[g], v && ilast[g], d}), // [R4] [R12]
      .last_in(v && ilast[g]),
      .dout(dent),
      .tail_out(dtail)
    );
    assign {dv, ds, dlast, dd} = dent;
    assign opos = ds ? 11'h000 : opos_reg;
    assign k_w = opos - (wbase_reg + WOFF);
    assign k_c = opos - (wbase_reg + psr_pkg::OFF_CORR);
    assign fcs = bad_reg ? crco_reg : ~crco_reg; // [R9]

    // Rewriter byte select
    always_comb
    begin
      ob = dd;
      mod = 1'b0;
      wsh = stamp_reg >> {wsize_reg - 11'h001 - k_w, 3'b000};
      csh = cnew_reg >> {3'h7 - k_c[2:0], 3'b000};
      fsh = fcs >> {tcnt_reg, 3'b000};
      spn = psr_pkg::ones_add(spare_reg, acc_reg);
      if (act_reg != psr_pkg::PSR_PASS_UNMODIFIED_ACTION)
      begin
        if (dtail)
          ob = fsh[7:0]; // [R7] [R9]
        else if (k_w < wsize_reg)
        begin
          ob = wsh[7:0]; // [R7] [R8] [R13]
          mod = 1'b1;
        end
        else if (corr_en_reg && k_c < psr_pkg::LEN_CORR)
        begin
          ob = csh[7:0]; // [R3] [R18]
          mod = 1'b1;
        end
        else if (ipk_reg[0] && opos[10:1] ==
                 psr_pkg::POS_UDP_CSUM[10:1])
          ob = 8'h00; // [R10]
        else if (ipk_reg[1] && opos == wbase_reg + mlen_reg)
          ob = spn[15:8]; // [R11]
        else if (ipk_reg[1] &&
                 opos == wbase_reg + mlen_reg + 11'h001)
          ob = spn[7:0]; // [R11]
      end
    end

    // Output counters, checksum fix-up sum and new CRC
    always_ff @(posedge clk)
    begin
      if (!resetn)
      begin
        opos_reg <= 11'h000;
        acc_reg <= 16'h0000;
        crco_reg <= psr_pkg::CRC_INIT;
        tcnt_reg <= 2'b00;
      end
      else if (dv)
      begin
        opos_reg <= opos + 11'h001; // [R8]
        tcnt_reg <= dtail ? tcnt_reg + 2'b01 : 2'b00;
        if (!dtail)
          crco_reg <= psr_pkg::crc_byte(
            ds ? psr_pkg::CRC_INIT : crco_reg, ob); // [R7]
        if (ds)
          acc_reg <= 16'h0000;
        else if (mod && ipk_reg[1])
          acc_reg <= psr_pkg::ones_add(
            psr_pkg::ones_add(acc_reg, opos[0] ?
              {8'h00, dd} : {dd, 8'h00}),
            opos[0] ? {8'h00, ~ob} : {~ob, 8'h00}); // [R11]
      end
    end

    // Registered byte stream toward the far coding layer
    always_ff @(posedge clk)
    begin
      if (!resetn)
      begin
        ov_reg <= 1'b0;
        osof_reg <= 1'b0;
        olast_reg <= 1'b0;
        odat_reg <= 8'h00;
      end
      else
      begin
        ov_reg <= dv; // [R8]
        osof_reg <= dv && ds;
        olast_reg <= dv && dlast;
        odat_reg <= dv ? ob : 8'h00;
      end
    end
  end

  assign ing_out_valid = dir[0].ov_reg;
  assign ing_out_sof = dir[0].osof_reg;
  assign ing_out_last = dir[0].olast_reg;
  assign ing_out_data = dir[0].odat_reg;
  assign egr_out_valid = dir[1].ov_reg;
  assign egr_out_sof = dir[1].osof_reg;
  assign egr_out_last = dir[1].olast_reg;
  assign egr_out_data = dir[1].odat_reg;

  // Egress sets saved when the frame's last byte enters
  psr_stamp_fifo #(
    .W(208),
    .DEPTH(TS_DEPTH)
  ) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .wr_valid(egr_in_valid && egr_in_last &&
              dir[1].save_reg), // [R15]
    .wr_data({dir[1].id_reg, dir[1].stamp_reg}), // [R15]
    .rd_req(ts_rd_req),
    .rd_valid(ts_rd_valid),
    .rd_data({ts_rd_id, ts_rd_stamp}), // [R16]
    .empty(ts_empty),
    .full(ts_full)
  );
endmodule : psr_stamp_rewriter
`default_nettype wire

/* File: verif/psr_stamp_rewriter_properties.sv */
// Port timing checks for the stamp rewriter.
// Assumes stream inputs stay idle while reset is low.
`timescale 1ns/1ps
`default_nettype none
module psr_props
#(
  parameter int DELAY = 16 // Delay depth
)
(
  input wire logic clk, // Clock
  input wire logic resetn, // Reset
  input wire logic ing_in_valid, // In
  input wire logic ing_in_sof, // In
  input wire logic ing_in_last, // In
  input wire logic ing_out_valid, // Out
  input wire logic ing_out_sof, // Out
  input wire logic ing_out_last, // Out
  input wire logic [7:0] ing_out_data, // Out
  input wire logic egr_in_valid, // In
  input wire logic egr_in_sof, // In
  input wire logic egr_out_valid, // Out
  input wire logic egr_out_sof, // Out
  input wire logic ts_rd_req, // Pop
  input wire logic ts_rd_valid, // Popped
  input wire logic ts_empty // Empty
);
  // A lag that drifts would skew every stamp
  int age = 0; // Edges seen, so $past has its full history
  always @(posedge clk)
    age <= age + 1;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn || age <= DELAY);
  AST_ING_VALID: assert property (
    ing_out_valid == $past(ing_in_valid, DELAY + 1)) else $error("ing v");
  AST_ING_SOF: assert property (
    ing_out_sof == $past(ing_in_sof, DELAY + 1)) else $error("ing sof");
  AST_ING_LAST: assert property (
    ing_out_last == $past(ing_in_last, DELAY + 1)) else $error("ing end");
  AST_EGR_VALID: assert property (
    egr_out_valid == $past(egr_in_valid, DELAY + 1)) else $error("egr v");
  AST_EGR_SOF: assert property (
    egr_out_sof == $past(egr_in_sof, DELAY + 1)) else $error("egr sof");
  AST_IDLE_ZERO: assert property (
    !ing_out_valid |-> ing_out_data == 8'h00) else $error("idle data");
  AST_POP_ANSWER: assert property (
    ts_rd_req && !ts_empty |=> ts_rd_valid) else $error("pop lost");
  AST_POP_CAUSE: assert property (
    ts_rd_valid |-> $past(ts_rd_req) && !$past(ts_empty))
    else $error("stray pop");
  cover property (ing_out_sof);
  cover property (egr_out_sof);
  cover property (ts_rd_valid);
endmodule : psr_props
bind psr_stamp_rewriter psr_props #(.DELAY(DELAY)) i_props (.*);
`default_nettype wire

/* File: verif/psr_stamp_rewriter_tb_top.sv */
// Bench: stamped frames both ways, passed frames on ingress, then a stamp pop.
// Assumes the bound checker and the local time model.
`timescale 1ns/1ps
`default_nettype none
module psr_stamp_rewriter_tb_top;
  localparam logic [31:0] NS = 32'h3B9ACA00; // One second
  logic clk = 1'b0, resetn = 1'b0, ts_rd_req = 1'b0;
  logic boundary_clock_mode = 1'b1, end_to_end_transit_clock = 1'b0;
  logic [7:0] domain_num = 8'h2C;
  logic [31:0] fixed_latency_ns = 32'h100; // Forces a wrap
  logic [63:0] link_asym = 64'h123450000;
  logic [6:0] id_offset = 7'h10; // Untouched on egress
  logic ing_in_valid, ing_in_sof, ing_in_last, egr_in_valid, egr_in_sof;
  logic egr_in_last, ing_out_valid, ing_out_sof, ing_out_last;
  logic egr_out_valid, egr_out_sof, egr_out_last, ts_rd_valid;
  logic ts_empty, ts_full;
  logic [7:0] ing_in_data, egr_in_data, ing_out_data, egr_out_data;
  logic [47:0] time_sec;
  logic [31:0] time_ns, t0, r;
  logic [127:0] ts_rd_id, id;
  logic [79:0] ts_rd_stamp, st;
  logic [7:0] f [64], o [64]; // Sent then expected; seen
  int err_total = 0, n_tests = 0, k = 0;
  always #20 clk = ~clk;
  psr_time_src i_time (.*);
  psr_stamp_rewriter i_dut (.*);
  // Collect output bytes
  always @(posedge clk)
    if (ing_out_valid || egr_out_valid)
    begin
      o[k % 64] <= ing_out_valid ? ing_out_data : egr_out_data;
      k <= k + 1;
    end
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Append FCS, bad on request
  task automatic fcs(input bit bad);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int i = 0; i < 480; i++)
      c = (c[0] ^ f[i / 8][i % 8]) ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    {f[63], f[62], f[61], f[60]} = ~c ^ {32{bad}};
  endtask : fcs
  task automatic drive(input bit eg, input logic [10:0] b);
    {egr_in_valid, egr_in_sof, egr_in_last, egr_in_data} = eg ? b : 11'h0;
    {ing_in_valid, ing_in_sof, ing_in_last, ing_in_data} = eg ? 11'h0 : b;
  endtask : drive
  // One PTP-on-L2 frame; hit picks the served domain
  task automatic run(input bit eg, input logic [3:0] mt, input bit hit,
    input bit bad);
    logic [47:0] s0;
    for (int i = 0; i < 60; i++)
      f[i] = (i < 22 || i > 29) ? i[7:0] : 8'h00;
    {f[12], f[13], f[14]} = {16'h88F7, 4'h0, mt};
    f[18] = hit ? domain_num : ~domain_num;
    fcs(bad);
    k = 0;
    for (int i = 0; i < 65; i++)
    begin
      @(negedge clk);
      if (i == 0)
        {s0, t0} = {time_sec, time_ns};
      drive(eg, {i < 64, i == 0, i == 63, f[i % 64]});
    end
    repeat (18) @(negedge clk);
    r = t0 + (t0 < fixed_latency_ns ? NS : 32'h0) - fixed_latency_ns;
    st = {s0, t0 + fixed_latency_ns};
    if (st[31:0] >= NS)
      st = {s0 + 48'h1, st[31:0] - NS};
    if (hit && boundary_clock_mode && !mt[3])
    begin
      // Stamp bytes
      for (int i = 0; i < 10; i++)
        f[eg ? 48 + i : 30 + i % 4] = eg ? st[79 - 8 * i -: 8]
          : r[31 - 8 * (i % 4) -: 8];
      for (int i = 0; i < 8; i++)
        f[22 + i] = (eg || mt == 4'h0) ? link_asym[63 - 8 * i -: 8] : 8'h00;
      fcs(bad);
    end
    for (int i = 0; i < 64; i++)
      chk(o[i], f[i]);
    $display("frame test done at %0t", $time);
  endtask : run
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude
  initial
  begin
    drive(1'b0, 11'h0);
    repeat (8) @(negedge clk);
    resetn = 1'b1;
    run(1'b0, 4'h0, 1'b1, 1'b0); // Sync stamped
    run(1'b0, 4'h0, 1'b1, 1'b1); // Sync, bad FCS
    run(1'b0, 4'h0, 1'b0, 1'b0); // Foreign domain
    run(1'b0, 4'h9, 1'b1, 1'b0); // Delay_resp
    boundary_clock_mode = 1'b0;
    run(1'b0, 4'h1, 1'b1, 1'b0); // Stamping off
    boundary_clock_mode = 1'b1;
    chk(ts_empty, 1'b1);
    run(1'b1, 4'h1, 1'b1, 1'b0); // Egress Delay_req saved
    for (int i = 0; i < 16; i++)
      id[127 - 8 * i -: 8] = f[30 + i];
    ts_rd_req = 1'b1;
    @(negedge clk);
    ts_rd_req = 1'b0;
    chk(ts_rd_valid, 1'b1);
    chk(ts_rd_stamp, st);
    chk(ts_rd_id, id);
    conclude();
  end
  // Six frames take about 510 cycles
  initial
  begin
    #130000;
    err_total++;
    conclude();
  end
endmodule : psr_stamp_rewriter_tb_top
`default_nettype wire

/* File: verif/psr_time_src.sv */
// Local time model for the stamp unit.
// Assumes the datapath clock; starts near a second edge.
`timescale 1ns/1ps
`default_nettype none
module psr_time_src
(
  input wire logic clk, // Clock
  input wire logic resetn, // Reset, active low
  output logic [47:0] time_sec, // Seconds
  output logic [31:0] time_ns // Nanoseconds
);
  // 40 ns a cycle; wraps early to test carries
  always_ff @(posedge clk)
  begin
    if (!resetn)
      {time_sec, time_ns} <= {48'h5, 32'h3B9AC9E0};
    else if (time_ns >= 32'h3B9AC9D8)
      {time_sec, time_ns} <= {time_sec + 48'h1, time_ns - 32'h3B9AC9D8};
    else
      time_ns <= time_ns + 32'h28;
  end
endmodule : psr_time_src
`default_nettype wire
